//--- rtl/mdpc_top.sv
// motor driver panel control: screens, operation data, parameters, test mode, edit lock
// assumes an APB master on pclk, external inputs from pins, core signals on pclk
// Notes on behaviour
// [RULE1] monitor lights one digit per I/O signal while on
// [RULE2] external voltage value readable in the monitor
// [RULE3] speed 50..4000 r/min, step 1, default 50
// [RULE4] torque limit 0..300 percent, default 300
// [RULE5] accel time to rated 3000 r/min, 0.1 s units, default 0.5
// [RULE6] decel time from rated speed, 0.0..15.0 s, default 0.5
// [RULE7] unit selection 1 refers ramp times to commanded speed
// [RULE8] init restores op data, parameters, all, or one number
// [RULE9] init hidden and refused under edit lock
// [RULE10] parameters addressed by unique id; sign chosen first
// [RULE11] nine-digit values entered as three parts, then combined
// [RULE12] class C parameters apply only on configuration
// [RULE13] no I/O or brake test entry while running; error instead
// [RULE14] fault lamp blinks orange in the I/O test
// [RULE15] I/O test ignores connector inputs, motor kept stopped
// [RULE16] I/O test engages a fitted brake
// [RULE17] holding dropped in I/O test, restored at test top
// [RULE18] I/O test shows inputs, forces outputs on or off
// [RULE19] brake test frees brake at standstill, not under alarm
// [RULE20] edit lock blocks local run and all editing
// [RULE21] edit lock changes only on a mode top screen
// [RULE22] local run ignores only the external run input
`timescale 1ns/1ps
module mdpc_top #(
  parameter int          N_DATA      = 4,
  parameter int          N_IN        = 8,
  parameter int          N_OUT       = 4,
  parameter int          VOLT_W      = 10,
  parameter int          RUN_BIT     = 0,
  parameter logic [15:0] ACC_UNIT_ID = 16'h0258,
  parameter int          BLINK_CYC   = mdpc_pkg::BLINK_CYC_DEF
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic [mdpc_pkg::AW-1:0] paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [N_IN-1:0]        ext_in,
  input  wire logic [VOLT_W-1:0]      ext_volt,
  input  wire logic [N_OUT-1:0]       drv_out,
  input  wire logic                   motor_running,
  input  wire logic                   alarm_active,
  input  wire logic                   brake_fitted,
  input  wire logic                   brake_core_rel,
  input  wire logic                   hold_enable,
  output logic      [N_IN-1:0]        io_in_eff,
  output logic                        run_cmd,
  output logic      [N_OUT-1:0]       io_out,
  output logic      [N_IN+N_OUT-1:0]  seg_lit,
  output logic                        brake_release,
  output logic                        hold_force,
  output logic                        fault_lamp_orange,
  output logic      [mdpc_pkg::DW-1:0] speed_cmd,
  output logic      [mdpc_pkg::DW-1:0] torque_lim,
  output logic      [mdpc_pkg::DW-1:0] accel_time,
  output logic      [mdpc_pkg::DW-1:0] decel_time,
  output logic      [mdpc_pkg::DW-1:0] ramp_ref_rpm,
  output logic                        cfg_done
);
  import mdpc_pkg::*;
  localparam int DSW = (N_DATA > 1) ? $clog2(N_DATA) : 1;
  localparam int BCW = $clog2(BLINK_CYC + 1);
  localparam logic [15:0] PAR_IDS [N_PAR] = '{ACC_UNIT_ID, P_ID_SRC, P_ID_DIR, P_ID_RED};
  localparam logic [31:0] PAR_DEF [N_PAR] = '{P_DEF_UNIT, P_DEF_SRC, P_DEF_DIR, P_DEF_RED};
  // id lookup shared by the commit path and the read path
  function automatic logic [2:0] find_slot(input logic [15:0] id);
    logic [2:0] res;
    res = 3'h0;
    for (int i = 0; i < N_PAR; i++) begin
      if (PAR_IDS[i] == id) begin
        res = {1'b1, 2'(i)};
      end
    end
    return res;
  endfunction : find_slot
  mdpc_screen_t    scr_ff;
  mdpc_screen_t    nxt_scr;
  logic            err_ff;
  logic            lock_ff;
  logic            lrun_ff;
  logic [DSW-1:0]  dsel_ff;
  logic [DW-1:0]   spd_ff [N_DATA];
  logic [DW-1:0]   trq_ff [N_DATA];
  logic [DW-1:0]   acc_ff [N_DATA];
  logic [DW-1:0]   dec_ff [N_DATA];
  logic [31:0]     eff_ff [N_PAR];
  logic [31:0]     pend_ff [N_PAR];
  logic [N_PAR-1:0] pendv_ff;
  logic [15:0]     pid_ff;
  logic [9:0]      pup_ff;
  logic [9:0]      pmid_ff;
  logic [9:0]      plo_ff;
  logic            psign_ff;
  logic [N_OUT-1:0] frc_ff;
  logic [31:0]     prdata_ff;
  logic [BCW-1:0]  bcnt_ff;
  logic            blink_ff;
  logic            cfg_done_ff;
  logic [N_IN-1:0] in_s;
  logic [31:0]     join_val;
  logic            parts_ok;
  logic [31:0]     rd_mux;
  // connector inputs come from pins
  mdpc_sync #(.W(N_IN)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (ext_in),
    .dout  (in_s)
  );
  // nine-digit value from its three parts
  mdpc_join u_join (
    .part_up  (pup_ff),
    .part_mid (pmid_ff),
    .part_lo  (plo_ff),
    .neg      (psign_ff),
    .value    (join_val),
    .parts_ok (parts_ok)
  ); // see [RULE11] see [RULE10]
  // bus decode; zero wait states, so a write lands at the access edge
  wire wr      = psel & penable & pwrite;
  wire mapped  = (paddr <= A_FRC) && (paddr[1:0] == 2'b00);
  wire h_cmd   = wr && paddr == A_CMD;
  wire h_stat  = wr && paddr == A_STAT;
  wire h_dsel  = wr && paddr == A_DSEL;
  wire h_spd   = wr && paddr == A_SPD;
  wire h_trq   = wr && paddr == A_TRQ;
  wire h_acc   = wr && paddr == A_ACC;
  wire h_dec   = wr && paddr == A_DEC;
  wire h_pid   = wr && paddr == A_PID;
  wire h_pup   = wr && paddr == A_PUP;
  wire h_pmid  = wr && paddr == A_PMID;
  wire h_plo   = wr && paddr == A_PLO;
  wire h_frc   = wr && paddr == A_FRC;
  wire [3:0] cmd = pwdata[3:0];
  wire [1:0] arg = pwdata[ARG_LSB+1:ARG_LSB];
  wire [DW-1:0] wv = pwdata[DW-1:0];
  wire wv_fit  = pwdata[31:DW] == '0;
  // screen-dependent conditions
  wire io_test = scr_ff == SCR_IO_TEST;
  wire brk_scr = scr_ff == SCR_BRK_TEST;
  wire at_top  = (scr_ff == SCR_TOP) || (scr_ff == SCR_TEST_TOP);
  wire on_ttop = scr_ff == SCR_TEST_TOP;
  // command acceptance; refusals raise the error flag
  wire c_iot   = h_cmd && cmd == C_GO_IOT;
  wire c_brk   = h_cmd && cmd == C_GO_BRK;
  wire iot_ok  = on_ttop && !motor_running; // see [RULE13]
  wire brk_ok  = on_ttop && !motor_running && !alarm_active; // see [RULE13] see [RULE19]
  wire c_lrun  = h_cmd && cmd == C_LRUN_ON;
  wire c_init  = h_cmd && cmd == C_INIT;
  wire c_conf  = h_cmd && cmd == C_CONFIG;
  wire c_comm  = h_cmd && cmd == C_COMMIT;
  wire c_lock  = h_cmd && (cmd == C_LOCK_ON || cmd == C_LOCK_OFF);
  wire [2:0] slot_w = find_slot(pid_ff);
  wire init_go = c_init && !lock_ff; // see [RULE9]
  wire comm_go = c_comm && !lock_ff && slot_w[2] && parts_ok; // see [RULE10] see [RULE20]
  wire lock_go = c_lock && at_top; // see [RULE21]
  wire init_op = init_go && (arg == INIT_OP || arg == INIT_ALL);
  wire init_pr = init_go && (arg == INIT_PAR || arg == INIT_ALL);
  wire init_1  = init_go && arg == INIT_ONE;
  // operation data edits, range checked and blocked by the lock
  wire spd_ok  = wv_fit && wv >= SPD_MIN && wv <= SPD_MAX; // see [RULE3]
  wire trq_ok  = wv_fit && wv <= TRQ_MAX; // see [RULE4]
  wire acc_ok  = wv_fit && wv >= ACC_MIN && wv <= TIME_MAX; // see [RULE5]
  wire dec_ok  = wv_fit && wv <= TIME_MAX; // see [RULE6]
  wire spd_go  = h_spd && !lock_ff && spd_ok; // see [RULE20]
  wire trq_go  = h_trq && !lock_ff && trq_ok;
  wire acc_go  = h_acc && !lock_ff && acc_ok;
  wire dec_go  = h_dec && !lock_ff && dec_ok;
  wire err_set = (c_iot && !iot_ok) || (c_brk && !brk_ok) || (c_lrun && lock_ff)
               || (c_init && lock_ff) || (c_comm && !comm_go) || (c_lock && !at_top)
               || (h_spd && !spd_go) || (h_trq && !trq_go)
               || (h_acc && !acc_go) || (h_dec && !dec_go);
  wire err_clr = h_stat && pwdata[ST_ERR];
  // next screen; refused moves leave the screen where it is
  assign nxt_scr = (h_cmd && cmd == C_GO_TOP)  ? SCR_TOP :
                   (h_cmd && cmd == C_GO_MON)  ? SCR_MON_IO :
                   (h_cmd && cmd == C_GO_EDIT) ? SCR_EDIT :
                   (h_cmd && cmd == C_GO_TEST) ? SCR_TEST_TOP :
                   (c_iot && iot_ok)           ? SCR_IO_TEST :
                   (c_brk && brk_ok)           ? SCR_BRK_TEST : scr_ff;
  // panel state; error set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scr_ff   <= SCR_TOP;
      err_ff   <= 1'b0;
      lock_ff  <= 1'b0;
      lrun_ff  <= 1'b0;
      dsel_ff  <= '0;
      pid_ff   <= '0;
      pup_ff   <= '0;
      pmid_ff  <= '0;
      plo_ff   <= '0;
      psign_ff <= 1'b0;
      frc_ff   <= '0;
    end else begin
      scr_ff  <= nxt_scr;
      err_ff  <= err_set | (err_ff & ~err_clr);
      if (lock_go) lock_ff <= cmd == C_LOCK_ON;
      if ((c_lrun && !lock_ff) || (h_cmd && cmd == C_LRUN_OFF)) begin
        lrun_ff <= cmd == C_LRUN_ON; // see [RULE20]
      end
      if (h_dsel) dsel_ff <= pwdata[DSW-1:0];
      if (h_pid)  pid_ff  <= pwdata[15:0];
      if (h_pup)  pup_ff  <= pwdata[9:0];
      if (h_pmid) pmid_ff <= pwdata[9:0];
      if (h_plo) begin
        plo_ff   <= pwdata[9:0];
        psign_ff <= pwdata[31]; // sign chosen before the commit
      end
      if (h_frc)  frc_ff  <= pwdata[N_OUT-1:0];
    end
  end
  // per data number storage; a write goes to the selected number
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N_DATA; i++) begin
        spd_ff[i] <= SPD_DEF;
        trq_ff[i] <= TRQ_DEF;
        acc_ff[i] <= TIME_DEF;
        dec_ff[i] <= TIME_DEF;
      end
    end else begin
      for (int i = 0; i < N_DATA; i++) begin
        if (init_op || (init_1 && dsel_ff == DSW'(i))) begin
          spd_ff[i] <= SPD_DEF; // see [RULE8]
          trq_ff[i] <= TRQ_DEF;
          acc_ff[i] <= TIME_DEF;
          dec_ff[i] <= TIME_DEF;
        end else if (dsel_ff == DSW'(i)) begin
          if (spd_go) spd_ff[i] <= wv; // see [RULE3]
          if (trq_go) trq_ff[i] <= wv; // see [RULE4]
          if (acc_go) acc_ff[i] <= wv; // see [RULE5]
          if (dec_go) dec_ff[i] <= wv; // see [RULE6]
        end
      end
    end
  end
  // parameter table; class C values wait in a pending copy until configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N_PAR; i++) begin
        eff_ff[i]  <= PAR_DEF[i];
        pend_ff[i] <= PAR_DEF[i];
      end
      pendv_ff    <= '0;
      cfg_done_ff <= 1'b0;
    end else begin
      cfg_done_ff <= c_conf;
      for (int i = 0; i < N_PAR; i++) begin
        if (init_pr) begin
          eff_ff[i]   <= PAR_DEF[i]; // see [RULE8]
          pend_ff[i]  <= PAR_DEF[i];
          pendv_ff[i] <= 1'b0;
        end else if (comm_go && slot_w[1:0] == 2'(i)) begin
          pend_ff[i] <= join_val;
          if (PAR_CLASS_C[i]) pendv_ff[i] <= 1'b1; // see [RULE12]
          else eff_ff[i] <= join_val;
        end else if (c_conf && pendv_ff[i]) begin
          eff_ff[i]   <= pend_ff[i]; // see [RULE12]
          pendv_ff[i] <= 1'b0;
        end
      end
    end
  end
  // orange blink runs only while the I/O test screen is up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt_ff  <= '0;
      blink_ff <= 1'b0;
    end else if (!io_test) begin
      bcnt_ff  <= '0;
      blink_ff <= 1'b1; // lamp lights at once on entry
    end else if (bcnt_ff == BCW'(BLINK_CYC - 1)) begin
      bcnt_ff  <= '0;
      blink_ff <= ~blink_ff; // see [RULE14]
    end else begin
      bcnt_ff  <= bcnt_ff + BCW'(1);
    end
  end
  // read data is captured in the setup cycle and held through the access
  wire [31:0] stat_w = {24'h0, |pendv_ff, scr_ff, ~lock_ff, lrun_ff, lock_ff, err_ff};
  always_comb begin
    unique case (paddr)
      A_STAT:  rd_mux = stat_w; // see [RULE9]
      A_DSEL:  rd_mux = 32'(dsel_ff);
      A_SPD:   rd_mux = 32'(spd_ff[dsel_ff]);
      A_TRQ:   rd_mux = 32'(trq_ff[dsel_ff]);
      A_ACC:   rd_mux = 32'(acc_ff[dsel_ff]);
      A_DEC:   rd_mux = 32'(dec_ff[dsel_ff]);
      A_PID:   rd_mux = 32'(pid_ff);
      A_PUP:   rd_mux = 32'(pup_ff);
      A_PMID:  rd_mux = 32'(pmid_ff);
      A_PLO:   rd_mux = {psign_ff, 21'h0, plo_ff};
      A_PVAL:  rd_mux = slot_w[2] ? eff_ff[slot_w[1:0]] : 32'h0;
      A_VOLT:  rd_mux = 32'(ext_volt); // see [RULE2]
      A_FRC:   rd_mux = 32'(frc_ff);
      default: rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_ff <= '0;
    else if (psel && !penable) prdata_ff <= rd_mux;
  end

  assign prdata  = prdata_ff;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  // driver-facing signals, registered
  wire             ext_run = in_s[RUN_BIT];
  wire [N_IN-1:0]  run_msk = N_IN'(1) << RUN_BIT;
  wire [N_IN-1:0]  in_pass = lrun_ff ? (in_s & ~run_msk) : in_s; // see [RULE22]
  wire             run_w   = !io_test && (lrun_ff || ext_run); // see [RULE15] see [RULE22]
  wire [N_OUT-1:0] out_w   = io_test ? frc_ff : drv_out; // see [RULE18]
  wire             show_io = (scr_ff == SCR_MON_IO) || io_test;
  wire             brk_w   = brk_scr ? (!motor_running && !alarm_active)
                           : (io_test ? !brake_fitted && brake_core_rel
                                      : brake_core_rel);
  wire             rel_ref = eff_ff[0] == UNIT_REL;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_in_eff     <= '0;
      run_cmd       <= 1'b0;
      io_out        <= '0;
      seg_lit       <= '0;
      brake_release <= 1'b0;
      speed_cmd     <= SPD_DEF;
      torque_lim    <= TRQ_DEF;
      accel_time    <= TIME_DEF;
      decel_time    <= TIME_DEF;
      ramp_ref_rpm  <= RATED_RPM;
    end else begin
      io_in_eff     <= io_test ? '0 : in_pass; // see [RULE15]
      run_cmd       <= run_w;
      io_out        <= out_w;
      seg_lit       <= show_io ? {io_out, in_s} : '0; // see [RULE1] see [RULE18]
      brake_release <= brk_w; // see [RULE16] see [RULE19]
      speed_cmd     <= spd_ff[dsel_ff];
      torque_lim    <= trq_ff[dsel_ff];
      accel_time    <= acc_ff[dsel_ff];
      decel_time    <= dec_ff[dsel_ff];
      ramp_ref_rpm  <= rel_ref ? spd_ff[dsel_ff] : RATED_RPM; // see [RULE5] see [RULE7]
    end
  end
  // holding force drops for the I/O test and returns on leaving it
  assign hold_force        = hold_enable && !io_test; // see [RULE17]
  assign fault_lamp_orange = io_test && blink_ff; // see [RULE14]
  assign cfg_done          = cfg_done_ff;

endmodule : mdpc_top

//--- shared/mdpc_pkg.sv
// motor driver panel control: register map, command codes, limits, defaults
// assumes a 32-bit APB register bus and a 100 MHz pclk
package mdpc_pkg;

  // register byte offsets, one aligned word each
  localparam int          AW     = 8;
  localparam logic [7:0]  A_CMD  = 8'h00;
  localparam logic [7:0]  A_STAT = 8'h04;
  localparam logic [7:0]  A_DSEL = 8'h08;
  localparam logic [7:0]  A_SPD  = 8'h0C;
  localparam logic [7:0]  A_TRQ  = 8'h10;
  localparam logic [7:0]  A_ACC  = 8'h14;
  localparam logic [7:0]  A_DEC  = 8'h18;
  localparam logic [7:0]  A_PID  = 8'h1C;
  localparam logic [7:0]  A_PUP  = 8'h20;
  localparam logic [7:0]  A_PMID = 8'h24;
  localparam logic [7:0]  A_PLO  = 8'h28;
  localparam logic [7:0]  A_PVAL = 8'h2C;
  localparam logic [7:0]  A_VOLT = 8'h30;
  localparam logic [7:0]  A_FRC  = 8'h34;

  // command codes written to the low nibble of the command register
  localparam logic [3:0]  C_GO_TOP   = 4'h0;
  localparam logic [3:0]  C_GO_MON   = 4'h1;
  localparam logic [3:0]  C_GO_EDIT  = 4'h2;
  localparam logic [3:0]  C_GO_TEST  = 4'h3;
  localparam logic [3:0]  C_GO_IOT   = 4'h4;
  localparam logic [3:0]  C_GO_BRK   = 4'h5;
  localparam logic [3:0]  C_LRUN_ON  = 4'h6;
  localparam logic [3:0]  C_LRUN_OFF = 4'h7;
  localparam logic [3:0]  C_INIT     = 4'h8;
  localparam logic [3:0]  C_CONFIG   = 4'h9;
  localparam logic [3:0]  C_COMMIT   = 4'hA;
  localparam logic [3:0]  C_LOCK_ON  = 4'hB;
  localparam logic [3:0]  C_LOCK_OFF = 4'hC;
  localparam int          ARG_LSB    = 4;

  // initialization scope in the command argument
  localparam logic [1:0]  INIT_OP  = 2'h0;
  localparam logic [1:0]  INIT_PAR = 2'h1;
  localparam logic [1:0]  INIT_ALL = 2'h2;
  localparam logic [1:0]  INIT_ONE = 2'h3;

  // status register bit positions
  localparam int ST_ERR   = 0;

  // operation data limits and factory values
  localparam int          DW        = 12;
  localparam logic [11:0] SPD_MIN   = 12'h032;
  localparam logic [11:0] SPD_MAX   = 12'hFA0;
  localparam logic [11:0] SPD_DEF   = 12'h032;
  localparam logic [11:0] TRQ_MAX   = 12'h12C;
  localparam logic [11:0] TRQ_DEF   = 12'h12C;
  localparam logic [11:0] ACC_MIN   = 12'h001;
  localparam logic [11:0] TIME_MAX  = 12'h096;
  localparam logic [11:0] TIME_DEF  = 12'h005;
  localparam logic [11:0] RATED_RPM = 12'hBB8;

  // parameter table: ids, factory values
  localparam int          N_PAR      = 4;
  localparam logic [15:0] P_ID_SRC   = 16'h071C;
  localparam logic [15:0] P_ID_DIR   = 16'h01C2;
  localparam logic [15:0] P_ID_RED   = 16'h07F1;
  localparam logic [31:0] P_DEF_UNIT = 32'h0000_0000;
  localparam logic [31:0] P_DEF_SRC  = 32'h0000_0000;
  localparam logic [31:0] P_DEF_DIR  = 32'h0000_0001;
  localparam logic [31:0] P_DEF_RED  = 32'h0000_0064;
  localparam logic [31:0] UNIT_REL   = 32'h0000_0001;
  localparam logic [3:0]  PAR_CLASS_C = 4'b0110;

  // nine-digit entry split into three parts of three digits
  localparam logic [9:0]  PART_MAX = 10'h3E7;
  localparam logic [31:0] MUL_UP   = 32'h000F_4240;
  localparam logic [31:0] MUL_MID  = 32'h0000_03E8;

  // lamp blink timing
  localparam int CLK_HZ        = 100_000_000;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_CYC_DEF = CLK_HZ / 1000 * BLINK_HALF_MS;

  // panel screens
  typedef enum logic [2:0] {
    SCR_TOP, SCR_MON_IO, SCR_EDIT, SCR_TEST_TOP, SCR_IO_TEST, SCR_BRK_TEST
  } mdpc_screen_t;

endpackage : mdpc_pkg

//--- rtl/mdpc_sync.sv
// three-stage pin synchronizer with agreement filter
// assumes din is asynchronous to clk
`timescale 1ns/1ps
module mdpc_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] q_ff;

  // a bit moves only when stages two and three agree, so a lone glitch is dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      q_ff  <= '0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff  <= (s2_ff & s3_ff) | (q_ff & (s2_ff ^ s3_ff));
    end
  end

  assign dout = q_ff;

endmodule : mdpc_sync

//--- rtl/mdpc_join.sv
// combines upper, middle and lower three-digit parts into one signed value
// assumes parts are held stable by the caller
`timescale 1ns/1ps
module mdpc_join (
  input  wire logic [9:0]  part_up,
  input  wire logic [9:0]  part_mid,
  input  wire logic [9:0]  part_lo,
  input  wire logic        neg,
  output logic      [31:0] value,
  output logic             parts_ok
);
  import mdpc_pkg::*;

  logic [31:0] mag;

  // upper*1e6 + middle*1e3 + lower; nine digits fit well inside 32 bits
  assign mag      = 32'(part_up) * MUL_UP + 32'(part_mid) * MUL_MID + 32'(part_lo);
  assign value    = neg ? (~mag + 32'h0000_0001) : mag;
  assign parts_ok = (part_up <= PART_MAX) && (part_mid <= PART_MAX) && (part_lo <= PART_MAX);

endmodule : mdpc_join

//--- verif/mdpc_monitor.sv
// checker on the panel control top ports
// assumes hold_enable is high while the I/O test is exercised
`timescale 1ns/1ps
module mdpc_monitor #(
  parameter int N_IN = 8
) (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [mdpc_pkg::AW-1:0] paddr,
  input wire logic [31:0]             pwdata,
  input wire logic                    motor_running,
  input wire logic                    alarm_active,
  input wire logic                    brake_fitted,
  input wire logic                    brake_core_rel,
  input wire logic                    hold_enable,
  input wire logic [N_IN-1:0]         io_in_eff,
  input wire logic                    run_cmd,
  input wire logic                    brake_release,
  input wire logic                    hold_force,
  input wire logic                    fault_lamp_orange,
  input wire logic [mdpc_pkg::DW-1:0] speed_cmd,
  input wire logic [mdpc_pkg::DW-1:0] torque_lim,
  input wire logic                    cfg_done
);
  import mdpc_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // I/O test seen as holding dropped while enabled; two cycles lets outputs settle
  sequence iot2_s;
    hold_enable && !hold_force ##1 hold_enable && !hold_force;
  endsequence
  sequence cfg_wr_s;
    psel && penable && pwrite && paddr == A_CMD && pwdata[3:0] == C_CONFIG;
  endsequence
  run_stop_a: assert property (iot2_s |-> !run_cmd && io_in_eff == '0)
    else $error("I/O test not isolated");
  brake_hold_a: assert property (iot2_s ##0 brake_fitted && $past(brake_fitted)
    |-> !brake_release) else $error("brake open in I/O test");
  lamp_entry_a: assert property ($fell(hold_force) && hold_enable
    && $past(hold_enable) |-> fault_lamp_orange) else $error("lamp dark on entry");
  hold_drop_a: assert property (hold_enable && fault_lamp_orange |-> !hold_force)
    else $error("holding kept");
  data_reset_a: assert property ($rose(presetn) |-> speed_cmd == SPD_DEF
    && torque_lim == TRQ_DEF) else $error("wrong factory data");
  data_range_a: assert property (speed_cmd >= SPD_MIN
    && speed_cmd <= SPD_MAX && torque_lim <= TRQ_MAX) else $error("data out of range");
  brake_test_a: assert property (brake_release && !$past(brake_core_rel)
    |-> !$past(motor_running) && !$past(alarm_active)) else $error("brake freed wrongly");
  cfg_pulse_a: assert property (cfg_wr_s |-> ##[1:2] (cfg_done ##1 !cfg_done))
    else $error("no config pulse");
endmodule : mdpc_monitor

//--- verif/mdpc_core_model.sv
// driver core stand-in: motor follows the run command, outputs walk
// assumes the pclk and presetn of the panel block
`timescale 1ns/1ps
module mdpc_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run_cmd,
  output logic            motor_running,
  output logic            brake_core_rel,
  output logic      [3:0] drv_out
);
  // one cycle spin-up; walking outputs so a stale copy shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motor_running <= 1'b0;
      drv_out       <= 4'h0;
    end else begin
      motor_running <= run_cmd;
      drv_out       <= drv_out + 4'h1;
    end
  end
  // brake lifts only while spinning
  assign brake_core_rel = motor_running;
endmodule : mdpc_core_model

//--- verif/mdpc_top_test.sv
// bench for panel control: APB tasks, core model, checker bound to uut
// assumes zero-wait APB answers and a 100 MHz pclk
`timescale 1ns/1ps
module mdpc_top_test;
  import mdpc_pkg::*;
  localparam logic [15:0] UNIT_ID = 16'h0258;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, alarm_active;
  logic        brake_fitted, hold_enable, motor_running, brake_core_rel, run_cmd;
  logic        brake_release, hold_force, fault_lamp_orange, cfg_done;
  logic [7:0]  paddr, ext_in, io_in_eff;
  logic [31:0] pwdata, prdata, q;
  logic [9:0]  ext_volt;
  logic [3:0]  drv_out, io_out;
  logic [11:0] seg_lit, speed_cmd, torque_lim, ramp_ref_rpm;
  int          num_errors, samples_checked;
  mdpc_top #(.BLINK_CYC(4), .ACC_UNIT_ID(UNIT_ID)) uut (.*, .accel_time(), .decel_time());
  mdpc_core_model core (.*);
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask : check
  task automatic wrap_up();
    $display("errors %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // one APB transfer, then an idle edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    paddr   <= a;
    pwdata  <= d;
    pwrite  <= w;
    psel    <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(q, e);
  endtask : rdc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  // sticky refusal flag: read, then clear
  task automatic err(input logic e);
    xfer(1'b0, A_STAT, 32'h0);
    check(32'(q[0]), 32'(e));
    wr(A_STAT, 32'h1);
  endtask : err
  task automatic cmd(input logic [3:0] c, input logic e, input logic [1:0] g = 2'h0);
    wr(A_CMD, {26'h0, g, c});
    err(e);
  endtask : cmd
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    wrap_up();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {alarm_active, brake_fitted, ext_in, ext_volt} = '0;
    hold_enable = 1'b1;
    num_errors = 0;
    samples_checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(A_SPD, 32'(SPD_DEF));
    rdc(A_TRQ, 32'(TRQ_DEF));
    rdc(A_ACC, 32'(TIME_DEF));
    rdc(A_DEC, 32'(TIME_DEF));
    check(32'(ramp_ref_rpm), 32'(RATED_RPM));
    wr(A_SPD, 32'h31);
    err(1'b1);
    wr(A_SPD, 32'hFA0);
    err(1'b0);
    wr(A_TRQ, 32'h12D);
    err(1'b1);
    wr(A_DEC, 32'h0);
    err(1'b0);
    ext_volt <= 10'h2A5;
    ext_in   <= 8'hA4;
    cmd(C_GO_MON, 1'b0);
    rdc(A_VOLT, 32'h2A5);
    check(32'(seg_lit[7:0]), 32'hA4);
    // nine digits in three parts, then a part beyond three digits
    wr(A_PID, 32'(P_ID_RED));
    wr(A_PUP, 32'h1);
    wr(A_PMID, 32'h2);
    wr(A_PLO, 32'h3E7);
    cmd(C_COMMIT, 1'b0);
    rdc(A_PVAL, MUL_UP + 32'h2 * MUL_MID + 32'h3E7);
    wr(A_PLO, 32'h3E8);
    cmd(C_COMMIT, 1'b1);
    wr(A_PID, 32'(P_ID_DIR));
    wr(A_PUP, 32'h0);
    wr(A_PMID, 32'h0);
    wr(A_PLO, 32'h0);
    cmd(C_COMMIT, 1'b0);
    rdc(A_PVAL, P_DEF_DIR);
    cmd(C_CONFIG, 1'b0);
    rdc(A_PVAL, 32'h0);
    wr(A_PID, 32'(UNIT_ID));
    wr(A_PLO, 32'h1);
    cmd(C_COMMIT, 1'b0);
    check(32'(ramp_ref_rpm), 32'hFA0);
    // test mode: refused while running, then I/O and brake tests
    cmd(C_GO_TEST, 1'b0);
    ext_in <= 8'hA5;
    cmd(C_LRUN_ON, 1'b0);
    check(32'(io_in_eff), 32'hA4);
    cmd(C_GO_IOT, 1'b1);
    ext_in <= 8'hA4;
    cmd(C_LRUN_OFF, 1'b0);
    cmd(C_GO_IOT, 1'b0);
    ext_in       <= 8'hA5;
    brake_fitted <= 1'b1;
    wr(A_FRC, 32'h9);
    // synced pins and registered outputs need edges; look between edges
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    check(32'(run_cmd), 32'h0);
    check(32'(io_out), 32'h9);
    check(32'(seg_lit[7:0]), 32'hA5);
    check(32'(brake_release), 32'h0);
    @(posedge pclk);
    ext_in <= 8'hA4;
    cmd(C_GO_TEST, 1'b0);
    check(32'(hold_force), 32'h1);
    alarm_active <= 1'b1;
    cmd(C_GO_BRK, 1'b1);
    alarm_active <= 1'b0;
    cmd(C_GO_BRK, 1'b0);
    check(32'(brake_release), 32'h1);
    cmd(C_LOCK_ON, 1'b1);
    cmd(C_GO_TOP, 1'b0);
    cmd(C_LOCK_ON, 1'b0);
    rdc(A_STAT, 32'h2);
    cmd(C_LRUN_ON, 1'b1);
    cmd(C_INIT, 1'b1, INIT_ALL);
    wr(A_TRQ, 32'h5);
    err(1'b1);
    cmd(C_LOCK_OFF, 1'b0);
    cmd(C_INIT, 1'b0, INIT_OP);
    rdc(A_SPD, 32'(SPD_DEF));
    wrap_up();
  end
endmodule : mdpc_top_test
bind mdpc_top mdpc_monitor #(.N_IN(N_IN)) mon (.*);
